// [periph_event_model.sv]
// Purpose: far-side timers and capture/compare unit making event strobes
// Assumes: strobes are one pclk cycle long and synchronous to pclk
// Notes:   the bench calls fire() to raise one strobe
`timescale 1ns/1ps
`default_nettype none
module periph_event_model (
    input  wire logic                         pclk,
    output var  periph_irq_pkg::periph_events_t events
);
    import periph_irq_pkg::*;

    // ---------------------------------------------------------------
    // strobe generator
    // ---------------------------------------------------------------
    initial events = '0;

    // idx 2 timer-3 overflow, 1 capture, 0 compare match
    task automatic fire(input int idx);
        @(posedge pclk);
        events <= periph_events_t'(3'(1 << idx));
        @(posedge pclk);
        events <= '0;
    endtask
endmodule
`default_nettype wire

// [periph_irq_flag_enable.sv]
// Purpose: timer-3 / capture-compare-2 request flags with enable gating
// Assumes: event strobes are one-cycle pulses synchronous to pclk
// Notes:   APB slave, zero-wait after one registered setup cycle
//
// Operation
// R1 - A timer-3 overflow sets flag bit 1 until software writes it zero.
// R2 - Capture mode: a timer-1 capture sets bit 0; a written zero clears it.
// R3 - Each peripheral source has its own enable bit to mask it alone.
// R4 - The peripheral enable bits are split over two enable registers; here both source enables sit in register b and a gates nothing.
// R5 - Priority levels off: a request needs the global enable to pass.
// R6 - An enable bit at one passes its source's request, at zero blocks it.
// R7 - Compare mode: a timer-1 match sets flag bit 0; pulse-width never does.
`timescale 1ns/1ps
`default_nettype none
module periph_irq_flag_enable (
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [periph_irq_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                       pwdata,
    output logic [31:0]                            prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    input  wire periph_irq_pkg::periph_events_t    events,
    output logic                                   periph_irq
);
    import periph_irq_pkg::*;

    // -------------------------------------------------------------------
    // apb slave
    // -------------------------------------------------------------------
    logic [31:0]          prdata_q, prdata_d;
    logic                 pready_q, pready_d;
    logic                 pslverr_q, pslverr_d;
    logic [EN_W-1:0]      en_a_q, en_a_d;
    logic [EN_W-1:0]      en_b_q, en_b_d;
    irq_ctrl_t            ctrl_q, ctrl_d;
    logic [NUM_FLAGS-1:0] flag_q;
    logic                 irq_q, irq_d;
    logic                 req;
    logic                 setup;
    logic                 wr_acc;
    logic                 mapped;
    logic                 wr_flag;
    logic                 set_cc2;

    // a write commits on the single access cycle; errors drop it
    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pready_q && pwrite && !pslverr_q;
    assign wr_flag = wr_acc && (paddr == OFFS_FLAG_B);

    always_comb begin
        case (paddr)
            OFFS_FLAG_B, OFFS_EN_A, OFFS_EN_B,
            OFFS_CTRL, OFFS_STATUS: mapped = 1'b1;
            default:                mapped = 1'b0;
        endcase
    end

    // read word is latched at setup and stands through the access
    always_comb begin
        pready_d  = setup;
        pslverr_d = setup && !mapped;
        prdata_d  = prdata_q;
        if (setup) begin
            prdata_d = ZERO_WORD;
            if (!pwrite) begin
                case (paddr)
                    OFFS_FLAG_B: prdata_d[NUM_FLAGS-1:0] = flag_q;
                    OFFS_EN_A:   prdata_d[EN_W-1:0]      = en_a_q;
                    OFFS_EN_B:   prdata_d[EN_W-1:0]      = en_b_q;
                    OFFS_CTRL:   prdata_d[CTRL_W-1:0]    = ctrl_q;
                    OFFS_STATUS: prdata_d[STATUS_IRQ_BIT] = irq_q;
                    default:     prdata_d = ZERO_WORD;
                endcase
            end
        end
    end

    // -------------------------------------------------------------------
    // enable and control registers
    // -------------------------------------------------------------------
    always_comb begin
        en_a_d = en_a_q;
        en_b_d = en_b_q;
        ctrl_d = ctrl_q;
        if (wr_acc && paddr == OFFS_EN_A) begin
            en_a_d = pwdata[EN_W-1:0];                             // R4
        end
        if (wr_acc && paddr == OFFS_EN_B) begin
            en_b_d = pwdata[EN_W-1:0];                             // R3
        end
        if (wr_acc && paddr == OFFS_CTRL) begin
            ctrl_d = irq_ctrl_t'(pwdata[CTRL_W-1:0]);
        end
    end

    // -------------------------------------------------------------------
    // request flags
    // -------------------------------------------------------------------
    // off and pulse-width modes never raise the capcomp2 flag
    always_comb begin
        case (ctrl_q.mode)
            MODE_CAPTURE: set_cc2 = events.capcomp2_capture;       // R2
            MODE_COMPARE: set_cc2 = events.capcomp2_match;         // R7
            MODE_PWM:     set_cc2 = 1'b0;                          // R7
            default:      set_cc2 = 1'b0;
        endcase
    end

    sticky_flag u_flag_timer3 (
        .pclk      (pclk),
        .presetn   (presetn),
        .set_pulse (events.timer3_ovf),                            // R1
        .wr_en     (wr_flag),
        .wr_val    (pwdata[BIT_TIMER3]),
        .flag_q    (flag_q[BIT_TIMER3])
    );

    sticky_flag u_flag_capcomp2 (
        .pclk      (pclk),
        .presetn   (presetn),
        .set_pulse (set_cc2),                                      // R2
        .wr_en     (wr_flag),
        .wr_val    (pwdata[BIT_CAPCOMP2]),
        .flag_q    (flag_q[BIT_CAPCOMP2])
    );

    // -------------------------------------------------------------------
    // request to the core
    // -------------------------------------------------------------------
    periph_req_gate u_gate (
        .flags   (flag_q),
        .enables (en_b_q[NUM_FLAGS-1:0]),                          // R6
        .ctrl    (ctrl_q),
        .req     (req)
    );

    // one cycle from flag to request keeps periph_irq a flop
    always_comb begin
        irq_d = req;                                               // R5
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= ZERO_WORD;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            en_a_q    <= EN_RESET;
            en_b_q    <= EN_RESET;
            ctrl_q    <= irq_ctrl_t'(CTRL_RESET);
            irq_q     <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            en_a_q    <= en_a_d;
            en_b_q    <= en_b_d;
            ctrl_q    <= ctrl_d;
            irq_q     <= irq_d;
        end
    end

    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign periph_irq = irq_q;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_T3_SET: assert property ( // R1
        events.timer3_ovf |=> flag_q[BIT_TIMER3])
        else $error("timer3 flag not set after overflow");

    AST_T3_HOLD: assert property ( // R1
        flag_q[BIT_TIMER3] && !wr_flag |=> flag_q[BIT_TIMER3])
        else $error("timer3 flag dropped without software write");

    AST_CAP_SET: assert property ( // R2
        ctrl_q.mode == MODE_CAPTURE && events.capcomp2_capture
        |=> flag_q[BIT_CAPCOMP2])
        else $error("capture did not set capcomp2 flag");

    AST_SRC_MASK: assert property ( // R3
        en_b_q[NUM_FLAGS-1:0] == 2'h0 |=> !periph_irq)
        else $error("request with all sources disabled");

    AST_EN_SPLIT: assert property ( // R4
        wr_acc && paddr == OFFS_EN_B |=> $stable(en_a_q))
        else $error("enable register a changed by write to b");

    AST_GLOBAL: assert property ( // R5
        !ctrl_q.priority_levels_on && !ctrl_q.global_periph_irq_enable
        |=> !periph_irq)
        else $error("request forwarded without global enable");

    AST_PASS: assert property ( // R6
        flag_q[BIT_TIMER3] && en_b_q[BIT_TIMER3] &&
        (ctrl_q.priority_levels_on || ctrl_q.global_periph_irq_enable)
        |=> periph_irq)
        else $error("enabled request not forwarded");

    AST_CMP_SET: assert property ( // R7
        ctrl_q.mode == MODE_COMPARE && events.capcomp2_match
        |=> flag_q[BIT_CAPCOMP2])
        else $error("compare match did not set capcomp2 flag");

    AST_PWM_QUIET: assert property ( // R7
        ctrl_q.mode == MODE_PWM && !flag_q[BIT_CAPCOMP2] && !wr_flag
        |=> !flag_q[BIT_CAPCOMP2])
        else $error("capcomp2 flag set in pulse-width mode");

    AST_T3_CLEAR: assert property ( // R1
        wr_flag && !pwdata[BIT_TIMER3] && !events.timer3_ovf
        |=> !flag_q[BIT_TIMER3])
        else $error("timer3 flag not cleared by written zero");

    AST_CC2_CLEAR: assert property ( // R2
        wr_flag && !pwdata[BIT_CAPCOMP2] && !set_cc2
        |=> !flag_q[BIT_CAPCOMP2])
        else $error("capcomp2 flag not cleared by written zero");

    AST_CC2_HOLD: assert property ( // R2
        flag_q[BIT_CAPCOMP2] && !wr_flag |=> flag_q[BIT_CAPCOMP2])
        else $error("capcomp2 flag dropped without software write");

    AST_CAP_ONLY: assert property ( // R2
        ctrl_q.mode == MODE_CAPTURE && !events.capcomp2_capture &&
        !flag_q[BIT_CAPCOMP2] && !wr_flag |=> !flag_q[BIT_CAPCOMP2])
        else $error("capcomp2 flag set in capture mode without capture");

    AST_CMP_ONLY: assert property ( // R7
        ctrl_q.mode == MODE_COMPARE && !events.capcomp2_match &&
        !flag_q[BIT_CAPCOMP2] && !wr_flag |=> !flag_q[BIT_CAPCOMP2])
        else $error("capcomp2 flag set in compare mode without match");

    AST_OFF_QUIET: assert property ( // R7
        ctrl_q.mode == MODE_OFF && !flag_q[BIT_CAPCOMP2] && !wr_flag
        |=> !flag_q[BIT_CAPCOMP2])
        else $error("capcomp2 flag set with the unit off");

    // -------------------------------------------------------------------
    // gating and enable register checks
    // -------------------------------------------------------------------

    AST_SRC_BLOCK: assert property ( // R6
        !(|(flag_q & en_b_q[NUM_FLAGS-1:0])) |=> !periph_irq)
        else $error("request forwarded from a blocked source");

    AST_CC2_PASS: assert property ( // R6
        flag_q[BIT_CAPCOMP2] && en_b_q[BIT_CAPCOMP2] &&
        (ctrl_q.priority_levels_on || ctrl_q.global_periph_irq_enable)
        |=> periph_irq)
        else $error("enabled capcomp2 request not forwarded");

    AST_EN_A_SPLIT: assert property ( // R4
        wr_acc && paddr == OFFS_EN_A |=> $stable(en_b_q))
        else $error("enable register b changed by write to a");

    AST_IRQ_STATUS: assert property ( // R5
        setup && !pwrite && paddr == OFFS_STATUS
        |=> prdata[STATUS_IRQ_BIT] == $past(periph_irq))
        else $error("status word differs from the request");

    // -------------------------------------------------------------------
    // bus handshake checks
    // -------------------------------------------------------------------

    AST_RDY_SETUP: assert property ( // R4
        setup |=> pready)
        else $error("no ready after a setup cycle");

    AST_RDY_PULSE: assert property ( // R4
        pready |=> !pready)
        else $error("ready held longer than one cycle");

    AST_ERR_RDY: assert property ( // R4
        pslverr |-> pready)
        else $error("error flagged without ready");

    AST_ERR_NOWRITE: assert property ( // R4
        psel && penable && pready && pslverr
        |=> $stable(en_b_q) && $stable(ctrl_q))
        else $error("refused write changed a register");

    // -------------------------------------------------------------------
    // coverage
    // -------------------------------------------------------------------

    COV_T3_IRQ: cover property (
        events.timer3_ovf ##2 periph_irq);
    COV_CAP_IRQ: cover property (
        ctrl_q.mode == MODE_CAPTURE && events.capcomp2_capture ##2 periph_irq);
    COV_CLEAR: cover property (
        flag_q[BIT_TIMER3] && wr_flag ##1 !flag_q[BIT_TIMER3]);
    COV_CMP_FLAG: cover property (
        ctrl_q.mode == MODE_COMPARE && events.capcomp2_match
        ##1 flag_q[BIT_CAPCOMP2]);
    COV_PRIO_IRQ: cover property (
        ctrl_q.priority_levels_on && !ctrl_q.global_periph_irq_enable &&
        periph_irq);

endmodule
`default_nettype wire

// [periph_irq_pkg.sv]
// Purpose: shared constants and types for the peripheral request slice
// Assumes: 32-bit APB register bus, one word per register
// Notes:   flag and enable positions match the request/enable registers
`default_nettype none
package periph_irq_pkg;

    // -------------------------------------------------------------------
    // register map (byte addresses)
    // -------------------------------------------------------------------
    localparam logic [7:0] OFFS_FLAG_B   = 8'h00;
    localparam logic [7:0] OFFS_EN_A     = 8'h04;
    localparam logic [7:0] OFFS_EN_B     = 8'h08;
    localparam logic [7:0] OFFS_CTRL     = 8'h0C;
    localparam logic [7:0] OFFS_STATUS   = 8'h10;
    localparam int         ADDR_W        = 8;

    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int BIT_CAPCOMP2     = 0;
    localparam int BIT_TIMER3       = 1;
    localparam int NUM_FLAGS        = 2;
    localparam int EN_W             = 8;
    localparam int CTRL_PRIO_BIT    = 0;
    localparam int CTRL_GLOBAL_BIT  = 1;
    localparam int CTRL_MODE_LSB    = 2;
    localparam int CTRL_W           = 4;
    localparam int STATUS_IRQ_BIT   = 0;

    // -------------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------------
    localparam logic [EN_W-1:0]      EN_RESET    = 8'h00;
    localparam logic [NUM_FLAGS-1:0] FLAG_RESET  = 2'h0;
    localparam logic [CTRL_W-1:0]    CTRL_RESET  = 4'h0;
    localparam logic [31:0]          ZERO_WORD   = 32'h0000_0000;

    // capture/compare unit mode, gray coded
    typedef enum logic [1:0] {
        MODE_OFF     = 2'h0,
        MODE_CAPTURE = 2'h1,
        MODE_COMPARE = 2'h3,
        MODE_PWM     = 2'h2
    } capcomp_mode_t;

    // event strobes from the timers and the capture/compare unit
    typedef struct packed {
        logic timer3_ovf;
        logic capcomp2_capture;
        logic capcomp2_match;
    } periph_events_t;

    // control fields
    typedef struct packed {
        capcomp_mode_t mode;
        logic          global_periph_irq_enable;
        logic          priority_levels_on;
    } irq_ctrl_t;

endpackage
`default_nettype wire

// [periph_req_gate.sv]
// Purpose: combine flags, per-source enables and global control
// Assumes: purely combinational, registered by the caller
// Notes:   with priority levels on, global enable does not gate
`timescale 1ns/1ps
`default_nettype none
module periph_req_gate (
    input  wire logic [periph_irq_pkg::NUM_FLAGS-1:0] flags,
    input  wire logic [periph_irq_pkg::NUM_FLAGS-1:0] enables,
    input  wire periph_irq_pkg::irq_ctrl_t            ctrl,
    output logic                                      req
);
    import periph_irq_pkg::*;

    logic any_src;

    always_comb begin
        any_src = |(flags & enables);                              // R3 R6
        req     = any_src &&
                  (ctrl.priority_levels_on ||
                   ctrl.global_periph_irq_enable);                 // R5
    end

endmodule
`default_nettype wire

// [sticky_flag.sv]
// Purpose: one hardware-set, software-written request flag
// Assumes: set and write are one-cycle strobes in the pclk domain
// Notes:   a set in the same cycle as a software write wins
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic set_pulse,
    input  wire logic wr_en,
    input  wire logic wr_val,
    output logic      flag_q
);
    import periph_irq_pkg::*;

    logic flag_d;

    always_comb begin
        flag_d = flag_q;
        if (wr_en) begin
            flag_d = wr_val;
        end
        if (set_pulse) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

endmodule
`default_nettype wire

// [tb.sv]
// Purpose: self-checking bench for the peripheral request slice
// Assumes: APB master tasks, event strobes from the partner model
// Notes:   expected values are literals; the mode loop derives its flags from MODE_CAPTURE and MODE_COMPARE
`timescale 1ns/1ps
`default_nettype none
module tb;
    import periph_irq_pkg::*;

    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = '0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              periph_irq;
    periph_events_t    events;
    logic [31:0]       rdat;
    logic              rerr;
    int                mismatches = 0;
    int                total_checks = 0;

    always #50 pclk = ~pclk;

    periph_irq_flag_enable i_periph_irq_flag_enable (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .events(events),
        .periph_irq(periph_irq));

    periph_event_model i_periph_event_model (.pclk(pclk), .events(events));

    // ---------------------------------------------------------------
    // bus and check tasks
    // ---------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            conclude();
        end else begin
            rdat = prdata;
            rerr = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e,
                      input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask

    task automatic irq_chk(input logic e);
        repeat (2) @(posedge pclk);
        chk("periph_irq", {31'h0, e}, {31'h0, periph_irq});
    endtask

    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFFS_FLAG_B, 32'h0, "flag reset");
        rd(OFFS_EN_A, 32'h0, "enable a reset");
        rd(OFFS_EN_B, 32'h0, "enable b reset");
        rd(OFFS_CTRL, 32'h0, "ctrl reset");
        rd(OFFS_STATUS, 32'h0, "status reset");
        $display("test reset done");

        wr(OFFS_EN_A, 32'h0000_00A5);
        wr(OFFS_EN_B, 32'hFFFF_FF5A);
        rd(OFFS_EN_A, 32'h0000_00A5, "enable a");
        rd(OFFS_EN_B, 32'h0000_005A, "enable b");
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, rerr});
        $display("test enables done");

        wr(OFFS_EN_B, 32'h2);
        wr(OFFS_CTRL, 32'h0);
        i_periph_event_model.fire(2);
        rd(OFFS_FLAG_B, 32'h2, "timer3 flag");
        irq_chk(1'b0);
        wr(OFFS_CTRL, 32'h2);
        irq_chk(1'b1);
        rd(OFFS_STATUS, 32'h1, "status irq");
        wr(OFFS_EN_B, 32'h1);
        irq_chk(1'b0);
        wr(OFFS_CTRL, 32'h1);
        wr(OFFS_EN_B, 32'h2);
        irq_chk(1'b1);
        rd(OFFS_FLAG_B, 32'h2, "timer3 flag held");
        wr(OFFS_FLAG_B, 32'h0);
        irq_chk(1'b0);
        rd(OFFS_FLAG_B, 32'h0, "timer3 cleared");
        $display("test timer3 done");

        wr(OFFS_EN_B, 32'h1);
        for (int m = 0; m < 4; m++) begin
            wr(OFFS_CTRL, 32'(m << 2) | 32'h2);
            i_periph_event_model.fire(1);
            rd(OFFS_FLAG_B, {31'h0, capcomp_mode_t'(m) == MODE_CAPTURE},
               "capture flag");
            irq_chk(capcomp_mode_t'(m) == MODE_CAPTURE);
            wr(OFFS_FLAG_B, 32'h0);
            i_periph_event_model.fire(0);
            rd(OFFS_FLAG_B, {31'h0, capcomp_mode_t'(m) == MODE_COMPARE},
               "match flag");
            wr(OFFS_FLAG_B, 32'h0);
        end
        rd(OFFS_FLAG_B, 32'h0, "flags cleared");
        $display("test capture compare done");
        conclude();
    end
endmodule
`default_nettype wire
